// File: core/srg_sysref_gen.sv
// Notes on behaviour
// - Auto-repeat waits wait-count SYSREF periods between bursts.
// - A burst has exactly pulse-count pulses, one for a count of zero; pulse count resets to one.
// - Mode 000 raw fanout, 001 synced fanout, 010 external, 011 internal (reset).
// - Mode 100 drives SYSREF continuously as a clock.
// - Mode 111 stops continuous generation; 101 and 110 are reserved.
// - Option 00: mode 010 rising trigger starts burst; mode 011 single burst.
// - Option 01, mode 010: falling trigger edge starts one burst.
// - Option 01, mode 011: bursts repeat with programmed wait between them.
// - Option 10, mode 010: rising edge starts pulsing, falling edge stops.
`timescale 1ns/1ps
`include "srg_defines.svh"
module srg_sysref_gen #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // SYSREF half-period enable from the SYSREF divider
   input wire logic sysref_tick_i,
   // Control fields
   input wire logic [CNT_W-1:0] burst_wait_count_i,
   input wire logic [CNT_W-1:0] burst_pulse_count_i,
   input wire srg_pkg::srg_mode_t generation_mode_select_i,
   input wire srg_pkg::srg_opt_t pulse_option_select_i,
   input wire logic mode_write_i,
   // Pins
   input wire logic external_trigger_input_i,
   // Outputs
   output logic sysref_o,
   output logic busy_o
);
   import srg_pkg::*;

   srg_state_t state;
   srg_state_t next_state;
   logic [2:0] trig_sync;
   logic trig_lvl;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic half;
   logic cont_on;
   logic sysref_q;
   logic gate_stop;
   logic run;

   wire mode_ext = generation_mode_select_i == `SRG_MODE_EXT;
   wire mode_int = generation_mode_select_i == `SRG_MODE_INT;
   wire opt_rise = pulse_option_select_i == `SRG_OPT_RISE;
   wire opt_fall = pulse_option_select_i == `SRG_OPT_FALL;
   wire opt_ghi = pulse_option_select_i == `SRG_OPT_GATE_HI;
   wire opt_glo = pulse_option_select_i == `SRG_OPT_GATE_LO;
   // Second and third stage must agree before a change counts
   wire agree = trig_sync[1] == trig_sync[2];
   wire rise = agree && trig_sync[2] && !trig_lvl;
   wire fall = agree && !trig_sync[2] && trig_lvl;
   wire period_end = sysref_tick_i && half;
   wire period_start = sysref_tick_i && !half;
   // Only periods that began inside the burst are counted
   wire beat_end = period_end && run;
   wire gate_end = (state == SRG_GATED) && (gate_off || gate_stop);
   wire mode_wr_int = mode_write_i && mode_int;
   wire start_ext = mode_ext && ((opt_rise && rise) || (opt_fall && fall));
   wire start_int = mode_wr_int && (opt_rise || opt_fall);
   wire gate_on = mode_ext && ((opt_ghi && rise) || (opt_glo && fall));
   wire gate_off = (opt_ghi && fall) || (opt_glo && rise) || !mode_ext;
   wire auto_rep = mode_int && opt_fall;
   wire pulse_wave = sysref_tick_i ? !half : half;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_sync <= 3'h0;
         trig_lvl <= 1'b0;
      end else begin
         trig_sync <= {trig_sync[1:0], external_trigger_input_i};
         if (agree)
            trig_lvl <= trig_sync[2];
      end
   end

   // Half-period phase: high half then low half of each SYSREF period
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         half <= 1'b0;
      else if (sysref_tick_i)
         half <= !half;
   end

   // Bursts begin on a period boundary, so no runt or lost pulse
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         run <= 1'b0;
      else if (state != SRG_BURST && state != SRG_GATED)
         run <= 1'b0;
      else if (period_start)
         run <= 1'b1;
   end

   // Stop code clears it; reserved codes leave it untouched
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         cont_on <= 1'b0;
      else if (mode_write_i && generation_mode_select_i == `SRG_MODE_CONT)
         cont_on <= 1'b1;
      else if (mode_write_i && generation_mode_select_i == `SRG_MODE_STOP)
         cont_on <= 1'b0;
   end

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         SRG_IDLE: begin
            if (start_ext || start_int) begin
               next_state = SRG_BURST;
               next_count = burst_pulse_count_i;
            end else if (gate_on) begin
               next_state = SRG_GATED;
            end
         end
         SRG_BURST: begin
            if (beat_end) begin
               next_count = count - 1'b1;
               if (count <= 1) begin
                  if (auto_rep && burst_wait_count_i != '0) begin
                     next_state = SRG_WAIT;
                     next_count = burst_wait_count_i;
                  end else if (auto_rep) begin
                     next_count = burst_pulse_count_i;
                  end else begin
                     next_state = SRG_IDLE;
                  end
               end
            end
         end
         SRG_WAIT: begin
            if (!auto_rep) begin
               next_state = SRG_IDLE;
            end else if (period_end) begin
               next_count = count - 1'b1;
               if (count <= 1) begin
                  next_state = SRG_BURST;
                  next_count = burst_pulse_count_i;
               end
            end
         end
         SRG_GATED: begin
            if (gate_end && (period_end || !half))
               next_state = SRG_IDLE;
         end
         default: begin
            next_state = SRG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= SRG_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Gated mode may finish its current period so no runt pulse leaves
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         gate_stop <= 1'b0;
      else if (state != SRG_GATED)
         gate_stop <= 1'b0;
      else if (gate_off)
         gate_stop <= 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         sysref_q <= 1'b0;
      else if (generation_mode_select_i == `SRG_MODE_FAN_RAW)
         sysref_q <= external_trigger_input_i;
      else if (generation_mode_select_i == `SRG_MODE_FAN_SYNC)
         sysref_q <= trig_lvl;
      else if (cont_on)
         sysref_q <= pulse_wave;
      else if (state == SRG_BURST || state == SRG_GATED)
         sysref_q <= pulse_wave && (run || period_start) && !(gate_end && !half);
      else
         sysref_q <= 1'b0;
   end

   assign sysref_o = sysref_q;
   assign busy_o = state != SRG_IDLE;

   // Helper: pulses seen in current burst
   logic [CNT_W:0] seen;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         seen <= '0;
      else if (state != SRG_BURST)
         seen <= '0;
      else if (beat_end)
         seen <= seen + 1'b1;
   end

   a_burst_len: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_BURST && !auto_rep) |-> (seen < {1'b0, burst_pulse_count_i} || seen == '0))
      else $error("burst ran past pulse count");
   a_wait_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_BURST && next_state == SRG_WAIT) |=> count == $past(burst_wait_count_i))
      else $error("wait count not loaded");
   a_ext_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_IDLE && mode_ext && opt_rise && rise) |=> state == SRG_BURST)
      else $error("rising trigger did not start burst");
   a_ext_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_IDLE && mode_ext && opt_fall && fall) |=> state == SRG_BURST)
      else $error("falling trigger did not start burst");
   a_repeat_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_WAIT && auto_rep && count == 8'h01 && period_end) |=> state == SRG_BURST)
      else $error("repeat did not resume");
   a_gate_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_IDLE && mode_ext && opt_ghi && rise) |=> state == SRG_GATED)
      else $error("gate did not open");
   a_gate_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == SRG_IDLE && mode_ext && opt_glo && fall) |=> state == SRG_GATED)
      else $error("inverted gate did not open");
   a_cont_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_write_i && generation_mode_select_i == `SRG_MODE_STOP) |=> !cont_on)
      else $error("stop code ignored");
   a_cont_run: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_write_i && generation_mode_select_i == `SRG_MODE_CONT) |=> cont_on)
      else $error("continuous mode not started");
   a_raw_fan: assert property (@(posedge clk_i) disable iff (rst_i)
      (generation_mode_select_i == `SRG_MODE_FAN_RAW) |=> sysref_o == $past(external_trigger_input_i))
      else $error("raw fanout wrong");
   a_sync_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      rise |-> $past(external_trigger_input_i, 2) && $past(external_trigger_input_i, 3))
      else $error("edge taken before stages agree");
endmodule

// File: pkg/srg_defines.svh
`ifndef SRG_DEFINES_SVH
`define SRG_DEFINES_SVH
`define SRG_WAIT_RST 8'h00
`define SRG_PCNT_RST 8'h01
`define SRG_MODE_RST 3'h3
`define SRG_OPT_RST 2'h0
`define SRG_MODE_FAN_RAW 3'h0
`define SRG_MODE_FAN_SYNC 3'h1
`define SRG_MODE_EXT 3'h2
`define SRG_MODE_INT 3'h3
`define SRG_MODE_CONT 3'h4
`define SRG_MODE_STOP 3'h7
`define SRG_OPT_RISE 2'h0
`define SRG_OPT_FALL 2'h1
`define SRG_OPT_GATE_HI 2'h2
`define SRG_OPT_GATE_LO 2'h3
`endif

// File: pkg/srg_pkg.sv
package srg_pkg;
   typedef enum logic [1:0] {
      SRG_IDLE,
      SRG_BURST,
      SRG_WAIT,
      SRG_GATED
   } srg_state_t;
   typedef logic [2:0] srg_mode_t;
   typedef logic [1:0] srg_opt_t;
endpackage

// File: tb/srg_partner.sv
`timescale 1ns/1ps
module srg_partner (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // SYSREF as seen by a converter
   input wire logic sysref_i,
   input wire logic clear_i,
   // Observations
   output logic [15:0] pulses_o,
   output logic [15:0] gap_o
);
   logic last;
   logic seen;
   logic [15:0] since;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         last <= 1'b0;
         seen <= 1'b0;
         since <= 16'h0000;
         pulses_o <= 16'h0000;
         gap_o <= 16'h0000;
      end else if (clear_i) begin
         last <= 1'b0;
         seen <= 1'b0;
         since <= 16'h0000;
         pulses_o <= 16'h0000;
         gap_o <= 16'h0000;
      end else begin
         last <= sysref_i;
         since <= since + 16'h0001;
         if (sysref_i && !last) begin
            pulses_o <= pulses_o + 16'h0001;
            since <= 16'h0001;
            seen <= 1'b1;
            // Longest spacing shows the repeat wait
            if (seen && since > gap_o) begin
               gap_o <= since;
            end
         end
      end
   end
endmodule

// File: tb/test_srg_sysref_gen.sv
`timescale 1ns/1ps
module test_srg_sysref_gen;
   import srg_pkg::*;
   logic clk_i = 0, rst_i = 1, tick = 0, mwr = 0, trig = 0, clr = 0, sysref, busy;
   logic [7:0] wcnt = 8'h00, pcnt = 8'h01;
   srg_mode_t mode = 3'h3;
   srg_opt_t opt = 2'h0;
   logic [15:0] pulses, gap;
   int seed = 24, n_errors = 0, checks_done = 0, n, w;
   always #5 clk_i = ~clk_i;
   always @(negedge clk_i) tick <= ~tick;
   srg_sysref_gen DUT (.clk_i(clk_i), .rst_i(rst_i), .sysref_tick_i(tick),
      .burst_wait_count_i(wcnt), .burst_pulse_count_i(pcnt),
      .generation_mode_select_i(mode), .pulse_option_select_i(opt), .mode_write_i(mwr),
      .external_trigger_input_i(trig), .sysref_o(sysref), .busy_o(busy));
   srg_partner far (.clk_i(clk_i), .rst_i(rst_i), .sysref_i(sysref), .clear_i(clr),
      .pulses_o(pulses), .gap_o(gap));
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task results;
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask
   task set_mode(input srg_mode_t m, input srg_opt_t o);
      cyc(1);
      mode = m;
      opt = o;
      mwr = 1;
      cyc(1);
      mwr = 0;
   endtask
   task clear;
      clr = 1;
      cyc(1);
      clr = 0;
   endtask
   task idle;
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) cyc(1);
      check("busy", busy, 0);
   endtask
   // Count zero behaves as one
   function logic [15:0] exp_pulses(input logic [7:0] c);
      return (c == 8'h00) ? 16'h0001 : {8'h00, c};
   endfunction
   initial begin
      cyc(6);
      rst_i = 0;
      set_mode(3'h0, 2'h0);
      repeat (8) begin
         trig = 1'($random(seed));
         cyc(1);
         check("fanout", sysref, trig);
      end
      // Counts at both ends of the field among random ones
      for (int i = 0; i < 4; i++) begin
         for (int o = 0; o < 2; o++) begin
            n = 2 + ($random(seed) & 7);
            pcnt = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : n[7:0];
            trig = (o == 1);
            cyc(8);
            set_mode(3'h2, o[1:0]);
            clear;
            trig = ~trig;
            cyc(8);
            idle;
            check("ext burst", pulses, exp_pulses(pcnt));
         end
      end
      clear;
      set_mode(3'h3, 2'h0);
      cyc(8);
      idle;
      check("int burst", pulses, exp_pulses(pcnt));
      w = 1 + ($random(seed) & 3);
      wcnt = w[7:0];
      pcnt = 8'h02;
      clear;
      set_mode(3'h3, 2'h1);
      cyc(16 * (w + 2) + 40);
      check("repeat gap", gap, 16'(4 * (w + 1)));
      set_mode(3'h2, 2'h0);
      idle;
      clear;
      set_mode(3'h4, 2'h0);
      cyc(40);
      check("continuous", 16'(pulses > 8), 1);
      set_mode(3'h7, 2'h0);
      cyc(8);
      clear;
      cyc(20);
      check("stopped", pulses, 0);
      for (int m = 5; m < 7; m++) begin
         set_mode(m[2:0], 2'h0);
         cyc(20);
         check("reserved", pulses, 0);
      end
      for (int o = 2; o < 4; o++) begin
         set_mode(3'h2, o[1:0]);
         trig = (o == 3);
         cyc(8);
         clear;
         trig = ~trig;
         cyc(30);
         check("gated busy", busy, 1);
         trig = ~trig;
         cyc(8);
         idle;
         check("gated ran", 16'(pulses > 4), 1);
      end
      results;
   end
   initial begin
      #200000;
      n_errors++;
      results;
   end
endmodule
